// [design/ots_supervisor.sv]
// Function
// - Direction bit 0 makes CCW forward, 1 makes CW forward; reference polarity kept.
// - Forward limit on allows forward motion; off blocks it, forward overtravel.
// - Reverse limit on allows reverse motion; off blocks it, reverse overtravel.
// - During overtravel, references away from the active limit still pass.
// - Forward limit enable: 1 uses input, 8 ignores it; applied at restart.
// - Reverse limit enable: 2 uses input, 8 ignores it; applied at restart.
// - Restart-latched stop method: coast, decel then clamp, decel then coast.
// - Zero clamp holds a position loop with zero position reference.
// - Under torque control overtravel always coasts and stays coasting.
// - Emergency stop torque 0 to 800 percent, default 800, immediate.
// - Applied stop torque never exceeds motor maximum torque.
// - Warning detection enable, default off, takes effect immediately.
// - Powered and enabled, an overtravel occurrence not opposite the active reference latches the warning code.
// - With a reference active, only the same-direction limit raises the warning.
// - With no reference, either limit raises the warning.
// - No warning while motor power is off.
// - Power-on during existing overtravel raises no warning.
// - Clear command clears warning unless a new occurrence lands in the same cycle; reappears only on new overtravel.
// - Exceeding an effective software limit also raises the warning.
// - Warning only reports; stop handling and commands are unaffected.
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "ots_defs.svh"
module ots_supervisor
  import ots_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        resetn_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        forward_limit_input_in,
  input  wire logic        reverse_limit_input_in,
  input  wire logic        motor_power_in,
  input  wire logic        torque_mode_in,
  input  wire logic        ref_fwd_in,
  input  wire logic        ref_rev_in,
  input  wire logic        motor_stopped_in,
  input  wire logic        soft_limit_fwd_in,
  input  wire logic        soft_limit_rev_in,
  input  wire logic [9:0]  motor_max_torque_in,
  output logic             motor_cw_fwd_out,
  output logic             ref_fwd_pass_out,
  output logic             ref_rev_pass_out,
  output logic             fwd_overtravel_out,
  output logic             rev_overtravel_out,
  output logic             decel_out,
  output logic             coast_out,
  output logic             zero_clamp_out,
  output logic [9:0]       estop_torque_out,
  output logic             limit_warning_out,
  output logic [15:0]      limit_warning_code_out
);

  function automatic logic [9:0] min10(input logic [9:0] a, input logic [9:0] b);
    min10 = (a < b) ? a : b;
  endfunction

  logic [31:0] setup_q;
  logic [31:0] act_q;
  logic        load_q;
  logic [9:0]  torque_q;
  logic        warn_en_q;
  logic        warn_q;
  logic [1:0]  fwd_sync_q;
  logic [1:0]  rev_sync_q;
  logic        fwd_prev_q;
  logic        rev_prev_q;
  logic        sfwd_prev_q;
  logic        srev_prev_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  ots_state_t  state_q;
  ots_state_t  state_d;
  ots_stop_t   stop_mode;
  logic        fwd_use;
  logic        rev_use;
  logic        fwd_ot;
  logic        rev_ot;
  logic        ot_hit;
  logic        wr_en;
  logic        setup_ph;
  logic        clr_cmd;
  logic        fwd_ev;
  logic        rev_ev;
  logic        warn_set;
  logic        map_hit;
  logic [31:0] rd_val;

  // APB: registered read data, so pready holds off the setup cycle only
  assign setup_ph    = psel_in & ~penable_in;
  assign pready_out  = psel_in & penable_in;
  assign wr_en       = psel_in & penable_in & pwrite_in;
  assign prdata_out  = prdata_q;
  assign pslverr_out = pslverr_q & pready_out;
  assign clr_cmd     = wr_en & ~pslverr_q & (paddr_in == `OTS_ADDR_CMD) &
                       pwdata_in[`OTS_CLR_BIT];

  always_comb begin
    map_hit = 1'b1;
    rd_val  = 32'h0000_0000;
    if (paddr_in == `OTS_ADDR_SETUP) begin
      rd_val = setup_q;
    end else if (paddr_in == `OTS_ADDR_TORQUE) begin
      rd_val[`OTS_TQ_F] = torque_q;
    end else if (paddr_in == `OTS_ADDR_WARN_EN) begin
      rd_val[`OTS_WEN_BIT] = warn_en_q;
    end else if (paddr_in == `OTS_ADDR_CMD) begin
      rd_val = 32'h0000_0000;
    end else if (paddr_in == `OTS_ADDR_STATUS) begin
      rd_val[`OTS_ST_WARN]    = warn_q;
      rd_val[`OTS_ST_FWD_OT]  = fwd_ot;
      rd_val[`OTS_ST_REV_OT]  = rev_ot;
      rd_val[`OTS_ST_POWER]   = motor_power_in;
      rd_val[`OTS_ST_STATE_F] = state_q;
      rd_val[`OTS_ST_CODE_F]  = warn_q ? `OTS_WARN_CODE : `OTS_NO_CODE;
    end else begin
      map_hit = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup_ph) begin
      prdata_q  <= pwrite_in ? 32'h0000_0000 : rd_val;
      pslverr_q <= ~map_hit | (paddr_in[1:0] != 2'h0);
    end
  end

  // Pending restart settings; the live copy only moves at a restart
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      setup_q <= `OTS_SETUP_RST;
    end else if (wr_en & ~pslverr_q & (paddr_in == `OTS_ADDR_SETUP)) begin
      setup_q <= pwdata_in & `OTS_SETUP_MASK;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      load_q <= 1'b1;
    end else begin
      load_q <= wr_en & ~pslverr_q & (paddr_in == `OTS_ADDR_CMD) &
                pwdata_in[`OTS_RESTART_BIT];
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      act_q <= `OTS_SETUP_RST;
    end else if (load_q) begin
      act_q <= setup_q;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      torque_q <= `OTS_TQ_RST;
    end else if (wr_en & ~pslverr_q & (paddr_in == `OTS_ADDR_TORQUE)) begin
      torque_q <= pwdata_in[`OTS_TQ_F];
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      warn_en_q <= 1'b0;
    end else if (wr_en & ~pslverr_q & (paddr_in == `OTS_ADDR_WARN_EN)) begin
      warn_en_q <= pwdata_in[`OTS_WEN_BIT];
    end
  end

  // Limit pins are asynchronous to the drive clock
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fwd_sync_q <= 2'h3;
      rev_sync_q <= 2'h3;
    end else begin
      fwd_sync_q <= {fwd_sync_q[0], forward_limit_input_in};
      rev_sync_q <= {rev_sync_q[0], reverse_limit_input_in};
    end
  end

  // Any code other than the ignore value keeps the limit armed, the safe side
  assign fwd_use   = act_q[`OTS_FWD_F] != `OTS_LIM_OFF;
  assign rev_use   = act_q[`OTS_REV_F] != `OTS_LIM_OFF;
  assign fwd_ot    = fwd_use & ~fwd_sync_q[1];
  assign rev_ot    = rev_use & ~rev_sync_q[1];
  assign stop_mode = ots_stop_t'(act_q[`OTS_STOP_F]);

  assign motor_cw_fwd_out   = act_q[`OTS_DIR_BIT];
  assign fwd_overtravel_out = fwd_ot;
  assign rev_overtravel_out = rev_ot;
  assign ref_fwd_pass_out   = ref_fwd_in & ~fwd_ot;
  assign ref_rev_pass_out   = ref_rev_in & ~rev_ot;
  assign ot_hit = (fwd_ot & ref_fwd_in) | (rev_ot & ref_rev_in);

  always_comb begin
    state_d = state_q;
    case (state_q)
      OTS_RUN: begin
        if (ot_hit) begin
          if (torque_mode_in || stop_mode == OTS_STOP_DEC_CLAMP ||
              stop_mode == OTS_STOP_DEC_COAST) begin
            state_d = torque_mode_in ? OTS_COAST : OTS_DECEL;
          end else begin
            state_d = OTS_COAST;
          end
        end
      end
      OTS_DECEL: begin
        if (!ot_hit) begin
          state_d = OTS_RUN;
        end else if (torque_mode_in) begin
          state_d = OTS_COAST;
        end else if (motor_stopped_in) begin
          state_d = (stop_mode == OTS_STOP_DEC_CLAMP) ? OTS_CLAMP : OTS_COAST;
        end
      end
      OTS_COAST: begin
        if (!ot_hit) begin
          state_d = OTS_RUN;
        end
      end
      OTS_CLAMP: begin
        if (!ot_hit) begin
          state_d = OTS_RUN;
        end else if (torque_mode_in) begin
          state_d = OTS_COAST;
        end
      end
      default: begin
        state_d = OTS_RUN;
      end
    endcase
  end

  // The warning never feeds this machine: it only reports
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= OTS_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  assign decel_out      = state_q == OTS_DECEL;
  assign coast_out      = state_q == OTS_COAST;
  assign zero_clamp_out = state_q == OTS_CLAMP;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      estop_torque_out <= `OTS_TQ_RST;
    end else begin
      estop_torque_out <= min10(min10(torque_q, `OTS_TQ_LIMIT),
                                motor_max_torque_in);
    end
  end

  // Edge detection: only a fresh occurrence counts, never a standing one
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fwd_prev_q  <= 1'b0;
      rev_prev_q  <= 1'b0;
      sfwd_prev_q <= 1'b0;
      srev_prev_q <= 1'b0;
    end else begin
      fwd_prev_q  <= fwd_ot;
      rev_prev_q  <= rev_ot;
      sfwd_prev_q <= soft_limit_fwd_in;
      srev_prev_q <= soft_limit_rev_in;
    end
  end

  assign fwd_ev = (fwd_ot & ~fwd_prev_q) |
                  (soft_limit_fwd_in & ~sfwd_prev_q);
  assign rev_ev = (rev_ot & ~rev_prev_q) |
                  (soft_limit_rev_in & ~srev_prev_q);
  assign warn_set = warn_en_q & motor_power_in & (
                    (fwd_ev & ~ref_rev_in) |
                    (rev_ev & ~ref_fwd_in));

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      warn_q <= 1'b0;
    end else if (warn_set) begin
      warn_q <= 1'b1;
    end else if (clr_cmd) begin
      warn_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      limit_warning_out      <= 1'b0;
      limit_warning_code_out <= `OTS_NO_CODE;
    end else begin
      limit_warning_out      <= warn_q;
      limit_warning_code_out <= warn_q ? `OTS_WARN_CODE : `OTS_NO_CODE;
    end
  end

  a_fwd_block_ref: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    fwd_ot |-> !ref_fwd_pass_out)
    else $error("forward reference passed into forward limit");

  a_rev_block_ref: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    rev_ot |-> !ref_rev_pass_out)
    else $error("reverse reference passed into reverse limit");

  a_opposite_ref_ok: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (fwd_ot && !rev_ot && ref_rev_in && !ref_fwd_in) |-> ref_rev_pass_out)
    else $error("reference away from limit was blocked");

  a_sync_two_ff: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (fwd_use && $past(fwd_use, 2)) |-> (fwd_ot == !$past(forward_limit_input_in, 2)))
    else $error("forward limit not seen two cycles late");

  a_torque_mode_coast: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (torque_mode_in && ot_hit) |=> (state_q == OTS_COAST))
    else $error("torque control did not coast on overtravel");

  a_clamp_after_stop: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (state_q == OTS_DECEL && ot_hit && !torque_mode_in && motor_stopped_in &&
     stop_mode == OTS_STOP_DEC_CLAMP) |=> zero_clamp_out)
    else $error("no zero clamp after deceleration stop");

  a_torque_clamped: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    ##1 (estop_torque_out <= $past(motor_max_torque_in)) &&
        (estop_torque_out <= `OTS_TQ_LIMIT))
    else $error("stop torque above motor or range limit");

  a_warn_needs_power: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    $rose(warn_q) |-> $past(motor_power_in) && $past(warn_en_q))
    else $error("warning raised while unpowered or disabled");

  a_warn_latched: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (warn_q && !clr_cmd) |=> warn_q [*1] ##1 (warn_q || $past(clr_cmd)))
    else $error("warning dropped without clear");

  a_warn_direction: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (!warn_q && ref_fwd_in && !ref_rev_in && !fwd_ev) |=> !warn_q)
    else $error("warning from limit opposite to reference");

  a_clear_works: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (clr_cmd && !warn_set) |=> !warn_q ##1 !limit_warning_out)
    else $error("clear command did not clear warning");

  a_code_follows: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    warn_set |=> ##1 (limit_warning_out && limit_warning_code_out == `OTS_WARN_CODE))
    else $error("warning code not shown two cycles after event");

endmodule

// [inc/ots_defs.svh]
`ifndef OTS_DEFS_SVH
`define OTS_DEFS_SVH
`define OTS_ADDR_SETUP    8'h00
`define OTS_ADDR_TORQUE   8'h04
`define OTS_ADDR_WARN_EN  8'h08
`define OTS_ADDR_CMD      8'h0C
`define OTS_ADDR_STATUS   8'h10
`define OTS_DIR_BIT       0
`define OTS_FWD_F         7:4
`define OTS_REV_F         11:8
`define OTS_STOP_F        13:12
`define OTS_SETUP_MASK    32'h0000_3FF1
`define OTS_SETUP_RST     32'h0000_0210
`define OTS_LIM_OFF       4'h8
`define OTS_TQ_F          9:0
`define OTS_TQ_LIMIT      10'h320
`define OTS_TQ_RST        10'h320
`define OTS_WEN_BIT       0
`define OTS_CLR_BIT       0
`define OTS_RESTART_BIT   1
`define OTS_ST_WARN       0
`define OTS_ST_FWD_OT     1
`define OTS_ST_REV_OT     2
`define OTS_ST_POWER      3
`define OTS_ST_STATE_F    5:4
`define OTS_ST_CODE_F     31:16
`define OTS_WARN_CODE     16'h09A0
`define OTS_NO_CODE       16'h0000
`endif

// [inc/ots_pkg.sv]
package ots_pkg;
  typedef enum logic [1:0] {
    OTS_STOP_COAST,
    OTS_STOP_DEC_CLAMP,
    OTS_STOP_DEC_COAST
  } ots_stop_t;
  typedef enum logic [1:0] {
    OTS_RUN,
    OTS_DECEL,
    OTS_COAST,
    OTS_CLAMP
  } ots_state_t;
endpackage

// [verification/ots_machine_model.sv]
`timescale 1ns/1ps
module ots_machine_model #(
  parameter int STOP_DLY = 3
) (
  input  wire logic clk_sys_in,
  input  wire logic decel_in,
  output logic      fwd_limit_out,
  output logic      rev_limit_out,
  output logic      stopped_out
);
  logic [3:0] cnt_q;
  initial begin
    fwd_limit_out = 1'b1;
    rev_limit_out = 1'b1;
  end
  // Spin-down takes a few cycles, so a stop is never seen at once
  always_ff @(posedge clk_sys_in) begin
    if (!decel_in) begin
      cnt_q <= 4'h0;
    end else if (!stopped_out) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  assign stopped_out = (cnt_q >= 4'(STOP_DLY));
  // Switches open (low) while the axis sits past its travel end
  task automatic set_limits(input logic fwd_on, input logic rev_on);
    @(posedge clk_sys_in);
    fwd_limit_out <= fwd_on;
    rev_limit_out <= rev_on;
  endtask
endmodule

// [verification/ots_supervisor_tb.sv]
`timescale 1ns/1ps
`include "ots_defs.svh"
module ots_supervisor_tb;
  logic        clk_sys;
  logic        resetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        fwd_pin;
  logic        rev_pin;
  logic        power;
  logic        tq_mode;
  logic        ref_fwd;
  logic        ref_rev;
  logic        stopped;
  logic        soft_fwd;
  logic        soft_rev;
  logic [9:0]  max_tq;
  logic        cw_fwd;
  logic        fwd_pass;
  logic        rev_pass;
  logic        fwd_ot;
  logic        rev_ot;
  logic        decel;
  logic        coast;
  logic        clamp;
  logic [9:0]  estop_tq;
  logic        warn;
  logic [15:0] warn_code;
  logic [31:0] rd;
  logic        err;
  int          num_errors;
  int          check_count;

  ots_supervisor u_ots_supervisor (
    .clk_sys_in(clk_sys), .resetn_in(resetn), .paddr_in(paddr), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .forward_limit_input_in(fwd_pin),
    .reverse_limit_input_in(rev_pin), .motor_power_in(power), .torque_mode_in(tq_mode),
    .ref_fwd_in(ref_fwd), .ref_rev_in(ref_rev), .motor_stopped_in(stopped),
    .soft_limit_fwd_in(soft_fwd), .soft_limit_rev_in(soft_rev),
    .motor_max_torque_in(max_tq), .motor_cw_fwd_out(cw_fwd), .ref_fwd_pass_out(fwd_pass),
    .ref_rev_pass_out(rev_pass), .fwd_overtravel_out(fwd_ot), .rev_overtravel_out(rev_ot),
    .decel_out(decel), .coast_out(coast), .zero_clamp_out(clamp),
    .estop_torque_out(estop_tq), .limit_warning_out(warn),
    .limit_warning_code_out(warn_code));

  ots_machine_model u_ots_machine_model (
    .clk_sys_in(clk_sys), .decel_in(decel), .fwd_limit_out(fwd_pin),
    .rev_limit_out(rev_pin), .stopped_out(stopped));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Setup changes only apply through a restart
  task automatic setup(input logic [31:0] val);
    apb(1'b1, `OTS_ADDR_SETUP, val);
    apb(1'b1, `OTS_ADDR_CMD, 32'h0000_0002);
    tick(3);
  endtask

  task automatic pulse(input logic f, input logic r);
    u_ots_machine_model.set_limits(f, r);
    tick(3);
    u_ots_machine_model.set_limits(1'b1, 1'b1);
    tick(5);
  endtask

  task automatic clear_warn();
    apb(1'b1, `OTS_ADDR_CMD, 32'h0000_0001);
    tick(3);
  endtask

  task automatic t_regs();
    apb(1'b0, `OTS_ADDR_SETUP, 32'h0);
    check(rd, `OTS_SETUP_RST);
    apb(1'b0, `OTS_ADDR_TORQUE, 32'h0);
    check(rd, 32'h0000_0320);
    apb(1'b0, `OTS_ADDR_WARN_EN, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, `OTS_ADDR_SETUP, 32'h0000_0211);
    tick(3);
    check({31'h0, cw_fwd}, 32'h0);
    setup(32'h0000_0211);
    check({31'h0, cw_fwd}, 32'h1);
    setup(`OTS_SETUP_RST);
  endtask

  task automatic t_torque();
    apb(1'b1, `OTS_ADDR_TORQUE, 32'h0000_01F4);
    max_tq <= 10'h12C;
    tick(3);
    check({22'h0, estop_tq}, 32'h0000_012C);
    @(posedge clk_sys);
    max_tq <= 10'h384;
    tick(3);
    check({22'h0, estop_tq}, 32'h0000_01F4);
    apb(1'b1, `OTS_ADDR_TORQUE, 32'h0000_0320);
    tick(3);
    check({22'h0, estop_tq}, 32'h0000_0320);
  endtask

  task automatic t_limits();
    @(posedge clk_sys);
    ref_fwd <= 1'b1;
    ref_rev <= 1'b1;
    u_ots_machine_model.set_limits(1'b0, 1'b1);
    tick(4);
    check({fwd_ot, rev_ot, fwd_pass, rev_pass}, 32'h9);
    @(posedge clk_sys);
    ref_fwd <= 1'b0;
    tick(1);
    check({30'h0, fwd_pass, rev_pass}, 32'h1);
    u_ots_machine_model.set_limits(1'b1, 1'b0);
    ref_fwd <= 1'b1;
    tick(4);
    check({fwd_ot, rev_ot, fwd_pass, rev_pass}, 32'h6);
    setup(32'h0000_0880);
    u_ots_machine_model.set_limits(1'b0, 1'b0);
    tick(4);
    check({fwd_ot, rev_ot, fwd_pass, rev_pass}, 32'h3);
    u_ots_machine_model.set_limits(1'b1, 1'b1);
    ref_fwd <= 1'b0;
    ref_rev <= 1'b0;
    setup(`OTS_SETUP_RST);
  endtask

  task automatic t_stop();
    for (int m = 0; m < 5; m++) begin
      setup(`OTS_SETUP_RST | ((m == 3) ? 32'h1000 : (m == 4) ? 32'h3000 : 32'(m) << 12));
      @(posedge clk_sys);
      tq_mode <= (m == 3);
      ref_fwd <= 1'b1;
      u_ots_machine_model.set_limits(1'b0, 1'b1);
      tick(4);
      check({decel, coast}, (m == 1 || m == 2) ? 32'h2 : 32'h1);
      tick(8);
      check({clamp, coast}, (m == 1) ? 32'h2 : 32'h1);
      u_ots_machine_model.set_limits(1'b1, 1'b1);
      ref_fwd <= 1'b0;
      tq_mode <= 1'b0;
      tick(5);
      check({decel, coast, clamp}, 32'h0);
    end
    setup(`OTS_SETUP_RST);
  endtask

  task automatic t_warn();
    pulse(1'b0, 1'b1);
    check({31'h0, warn}, 32'h0);
    apb(1'b1, `OTS_ADDR_WARN_EN, 32'h1);
    power <= 1'b0;
    pulse(1'b0, 1'b1);
    check({31'h0, warn}, 32'h0);
    u_ots_machine_model.set_limits(1'b0, 1'b1);
    tick(5);
    @(posedge clk_sys);
    power <= 1'b1;
    tick(5);
    check({31'h0, warn}, 32'h0);
    u_ots_machine_model.set_limits(1'b1, 1'b1);
    tick(5);
    pulse(1'b0, 1'b1);
    check({15'h0, warn, warn_code}, 32'h0001_09A0);
    apb(1'b0, `OTS_ADDR_TORQUE, 32'h0);
    check(rd, 32'h0000_0320);
    u_ots_machine_model.set_limits(1'b0, 1'b1);
    tick(4);
    clear_warn();
    tick(6);
    check({15'h0, warn, warn_code}, 32'h0);
    u_ots_machine_model.set_limits(1'b1, 1'b1);
    pulse(1'b0, 1'b1);
    check({31'h0, warn}, 32'h1);
    clear_warn();
    pulse(1'b1, 1'b0);
    check({31'h0, warn}, 32'h1);
    clear_warn();
    @(posedge clk_sys);
    ref_fwd <= 1'b1;
    pulse(1'b1, 1'b0);
    check({31'h0, warn}, 32'h0);
    pulse(1'b0, 1'b1);
    check({31'h0, warn}, 32'h1);
    clear_warn();
    @(posedge clk_sys);
    ref_fwd <= 1'b0;
    soft_fwd <= 1'b1;
    tick(3);
    @(posedge clk_sys);
    soft_fwd <= 1'b0;
    tick(3);
    check({31'h0, warn}, 32'h1);
    clear_warn();
  endtask

  task automatic stop_test();
    if (num_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    stop_test();
  end

  initial begin
    num_errors = 0;
    check_count = 0;
    resetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {power, tq_mode, ref_fwd, ref_rev, soft_fwd, soft_rev} = 6'h20;
    max_tq = 10'h3E8;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    tick(2);
    check({22'h0, estop_tq}, 32'h0000_0320);
    t_regs();
    t_torque();
    t_limits();
    t_stop();
    t_warn();
    stop_test();
  end
endmodule
